/* File: include/mdmd_regs.svh */
// Register offsets, field positions, reset values and frame counts of the
// memory display mode decoder. Assumes inclusion by bare name from the design.
`ifndef MDMD_REGS_SVH
`define MDMD_REGS_SVH

// Byte offsets on the AHB-Lite register window.
`define MDMD_CTRL_OFS      8'h00
`define MDMD_STATUS_OFS    8'h04
`define MDMD_HEADER_OFS    8'h08
`define MDMD_COUNT_OFS     8'h0C

// Control register fields and reset value.
`define MDMD_CTRL_EN_BIT   0
`define MDMD_CTRL_RST      1'h1

// Status register field positions.
`define MDMD_ST_MODE_LSB   0
`define MDMD_ST_MODE_MSB   2
`define MDMD_ST_COM_BIT    3
`define MDMD_ST_MODEF_BIT  4
`define MDMD_ST_CLRF_BIT   5
`define MDMD_ST_BLINK_BIT  6
`define MDMD_ST_BCOL_BIT   7
`define MDMD_ST_BINV_BIT   8
`define MDMD_ST_DONE_BIT   9
`define MDMD_ST_ACT_BIT    10

// Serial frame layout in serial clocks.
`define MDMD_MODE_BITS     5'h06
`define MDMD_FILLER_BITS   5'h0A
`define MDMD_FRAME_BITS    5'h10

// AHB-Lite encodings used by the slave.
`define MDMD_HTRANS_NSEQ   2'h2
`define MDMD_HRESP_OKAY    1'h0

`endif

/* File: include/mdmd_pkg.sv */
// Types shared by the memory display mode decoder.
// Assumes the register header is included alongside by the design file.
package mdmd_pkg;

	// The six mode bits in arrival order; the first bit lands in the lsb.
	typedef struct packed {
		logic blinkInvFlag;
		logic blinkColorFlag;
		logic blinkFlag;
		logic clearFlag;
		logic comPolarityFlag;
		logic modeFlag;
	} mdmd_header_s;

	// What the panel shows as a result of the latched flags.
	typedef enum logic [2:0] {
		MDMD_NO_UPDATE,
		MDMD_DATA_UPDATE,
		MDMD_ALL_CLEAR,
		MDMD_BLINK_COLOR,
		MDMD_COLOR_INVERT
	} mdmd_mode_e;

	// Receiver phases within one serial frame.
	typedef enum logic [1:0] {
		MDMD_IDLE,
		MDMD_MODE_BITS,
		MDMD_FILLER,
		MDMD_DONE
	} mdmd_state_e;

	// Panel-side results of the decoder.
	typedef struct packed {
		mdmd_mode_e displayMode;
		logic       blinkWhite;
		logic       allClearStrobe;
		logic       dataUpdateActive;
	} mdmd_panel_s;

endpackage

/* File: hdl/mdmd_decoder.sv */
// Mode header decoder of a memory-in-pixel display panel, with an AHB-Lite
// register window. Assumes every panel pin is asynchronous to mclk and that
// the serial clock is slow enough for mclk to see both of its levels.
//
// Contract
// R01: A command frame is six mode bits then ten filler clocks.
// R02: The ten filler bits after the mode bits are ignored at any level.
// R03: Equal mode_flag and clear_flag select no-update; memory and image kept.
// R04: In plain no-update the blink colour and inversion bits are ignored.
// R05: mode_flag low with clear_flag high erases the displayed image.
// R06: Blinking wins over all-clear in what the display shows.
// R07: In all-clear, blink colour and inversion count only with blink_flag high.
// R08: Low mode, clear, inversion with blink high forces a uniform blink colour.
// R09: Blink colour is white when blink_color_flag is high, else black.
// R10: A command with blink_flag low ends blinking and returns to no-update; the code leaves blinking as it is for a data update command.
// R11: blink_flag and blink_inv_flag high show every pixel complemented.
// R12: blink_color_flag matters only while blink_inv_flag is low.
// R13: mode_flag and clear_flag clear when serial_select goes low.
// R14: Blink flags clear when display_on goes low, not by serial_select.
// R15: With com_source_select low the common electrode follows com_polarity_flag.
// R16: With com_source_select high com_polarity_flag is ignored.
// R17: With com_source_select high each toggle-input rising edge flips polarity.
// R18: The host keeps positive and negative polarity periods about equal.
// R19: mode_flag high and clear_flag low select data update mode.
// R20: Bits shift in per serial clock; the command acts after six bits.
`timescale 1ns/10ps

`include "mdmd_regs.svh"

module mdmd_decoder
	import mdmd_pkg::*;
#(
	parameter int SYNC_STAGES = 2
) (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rstn,
	// Serial command port from the host controller.
	input  wire logic        serialSelect,
	input  wire logic        serialClk,
	input  wire logic        serialData,
	// Panel control pins.
	input  wire logic        displayOn,
	input  wire logic        comSourceSelect,
	input  wire logic        extComToggleIn,
	// Panel-side results.
	output mdmd_panel_s      panelOut,
	output logic             commonElectrodeOut,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp
);

	// Pin synchronisers: one generate stage per pin, the second flop feeds logic.
	localparam int NPINS = 6;

	logic [NPINS-1:0] pinRaw;
	logic [NPINS-1:0] pinSync;

	assign pinRaw = {extComToggleIn, comSourceSelect, displayOn,
		serialData, serialClk, serialSelect};

	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++) begin : gSync
			logic [SYNC_STAGES-1:0] stage_reg;
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					stage_reg <= '0;
				end else begin
					stage_reg <= {stage_reg[SYNC_STAGES-2:0], pinRaw[gi]};
				end
			end
			assign pinSync[gi] = stage_reg[SYNC_STAGES-1];
		end
	endgenerate

	logic selS;
	logic sclkS;
	logic sdataS;
	logic dispS;
	logic extModeS;
	logic extComS;

	assign selS     = pinSync[0];
	assign sclkS    = pinSync[1];
	assign sdataS   = pinSync[2];
	assign dispS    = pinSync[3];
	assign extModeS = pinSync[4];
	assign extComS  = pinSync[5];

	// Edge history of synchronised pins; the synchronised level is safe to compare.
	logic sclkPrev_reg;
	logic extComPrev_reg;
	logic selPrev_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sclkPrev_reg   <= 1'b0;
			extComPrev_reg <= 1'b0;
			selPrev_reg    <= 1'b0;
		end else begin
			sclkPrev_reg   <= sclkS;
			extComPrev_reg <= extComS;
			selPrev_reg    <= selS;
		end
	end

	logic sclkRise;
	logic extComRise;

	assign sclkRise   = sclkS && !sclkPrev_reg && selS;
	assign extComRise = extComS && !extComPrev_reg;

	// Control register: decoding is on from reset and can be switched off by software.
	logic ctrlEnable_reg;

	// Frame receiver.
	mdmd_state_e  state_reg;
	logic [4:0]   bitCount_reg;
	logic [5:0]   shift_reg;
	logic         commit;
	mdmd_header_s header;

	assign header = mdmd_header_s'({sdataS, shift_reg[5:1]});
	assign commit = sclkRise && (state_reg == MDMD_MODE_BITS) &&
		(bitCount_reg == `MDMD_MODE_BITS - 5'h01); // R20

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg    <= MDMD_IDLE;
			bitCount_reg <= 5'h00;
			shift_reg    <= 6'h00;
		end else if (!selS) begin
			state_reg    <= MDMD_IDLE;
			bitCount_reg <= 5'h00;
		end else begin
			case (state_reg)
				MDMD_IDLE: begin
					if (ctrlEnable_reg && !selPrev_reg) begin
						state_reg <= MDMD_MODE_BITS;
					end
				end
				MDMD_MODE_BITS: begin
					if (sclkRise) begin
						shift_reg    <= {sdataS, shift_reg[5:1]}; // R20
						bitCount_reg <= bitCount_reg + 5'h01;
						if (commit) begin
							state_reg <= MDMD_FILLER;
						end
					end
				end
				MDMD_FILLER: begin
					// Filler levels are counted but never looked at.
					if (sclkRise) begin
						bitCount_reg <= bitCount_reg + 5'h01; // R02
						if (bitCount_reg == `MDMD_FRAME_BITS - 5'h01) begin
							state_reg <= MDMD_DONE; // R01
						end
					end
				end
				MDMD_DONE: begin
					state_reg <= MDMD_DONE;
				end
				default: begin
					state_reg <= MDMD_IDLE;
				end
			endcase
		end
	end

	// Mode and clear flags live only while the frame is selected.
	logic modeFlag_reg;
	logic clearFlag_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			modeFlag_reg  <= 1'b0;
			clearFlag_reg <= 1'b0;
		end else if (!selS) begin
			modeFlag_reg  <= 1'b0; // R13
			clearFlag_reg <= 1'b0; // R13
		end else if (commit) begin
			modeFlag_reg  <= header.modeFlag;
			clearFlag_reg <= header.clearFlag;
		end
	end

	// Blink flags survive frame ends; display_on low or a non-data command with blink_flag low drops them.
	// In data update the third bit means data width, so blink state is left alone.
	logic blinkFlag_reg;
	logic blinkColor_reg;
	logic blinkInv_reg;
	logic dataCmd;

	assign dataCmd = header.modeFlag && !header.clearFlag; // R19

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			blinkFlag_reg  <= 1'b0;
			blinkColor_reg <= 1'b0;
			blinkInv_reg   <= 1'b0;
		end else if (!dispS) begin
			blinkFlag_reg  <= 1'b0; // R14
			blinkColor_reg <= 1'b0; // R14
			blinkInv_reg   <= 1'b0; // R14
		end else if (commit && !dataCmd) begin
			blinkFlag_reg  <= header.blinkFlag; // R10
			blinkColor_reg <= header.blinkFlag && header.blinkColorFlag; // R04 R07
			blinkInv_reg   <= header.blinkFlag && header.blinkInvFlag; // R04 R07
		end
	end

	// Common electrode polarity.
	logic com_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			com_reg <= 1'b0;
		end else if (extModeS) begin
			if (extComRise) begin
				com_reg <= !com_reg; // R16 R17
			end
		end else if (commit) begin
			com_reg <= header.comPolarityFlag; // R15
		end
	end

	// Display result; blinking outranks the clear in what is shown.
	mdmd_mode_e modeNext;

	always_comb begin
		if (blinkFlag_reg && blinkInv_reg) begin
			modeNext = MDMD_COLOR_INVERT; // R11 R12
		end else if (blinkFlag_reg) begin
			modeNext = MDMD_BLINK_COLOR; // R06 R08
		end else if (!modeFlag_reg && clearFlag_reg) begin
			modeNext = MDMD_ALL_CLEAR; // R05
		end else if (modeFlag_reg && !clearFlag_reg) begin
			modeNext = MDMD_DATA_UPDATE; // R19
		end else begin
			modeNext = MDMD_NO_UPDATE; // R03
		end
	end

	// The erase strobe fires once per all-clear command even under blinking,
	// since the stored image is cleared either way.
	logic clearCmd;

	assign clearCmd = !header.modeFlag && header.clearFlag;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			panelOut <= '{displayMode: MDMD_NO_UPDATE, default: 1'b0};
		end else begin
			panelOut.displayMode      <= modeNext;
			panelOut.blinkWhite       <= blinkColor_reg && !blinkInv_reg; // R09 R12
			panelOut.allClearStrobe   <= commit && clearCmd; // R05
			panelOut.dataUpdateActive <= modeFlag_reg && !clearFlag_reg && selS; // R19
		end
	end

	assign commonElectrodeOut = com_reg;

	// Host-facing bookkeeping.
	logic [5:0]  lastHeader_reg;
	logic [31:0] cmdCount_reg;
	logic        frameDone_reg;

	// AHB-Lite slave: address phase captured, write or read in the data phase.
	logic       apValid;
	logic       dpWrite_reg;
	logic [7:0] dpAddr_reg;
	logic       countClr;

	assign apValid  = hsel && hready && (htrans == `MDMD_HTRANS_NSEQ);
	assign countClr = dpWrite_reg && (dpAddr_reg == `MDMD_COUNT_OFS);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dpWrite_reg <= 1'b0;
			dpAddr_reg  <= 8'h00;
			hreadyout   <= 1'b1;
			hresp       <= `MDMD_HRESP_OKAY;
		end else begin
			dpWrite_reg <= apValid && hwrite;
			dpAddr_reg  <= {haddr[7:2], 2'h0};
			hreadyout   <= 1'b1;
			hresp       <= `MDMD_HRESP_OKAY;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrlEnable_reg <= `MDMD_CTRL_RST;
		end else if (dpWrite_reg && (dpAddr_reg == `MDMD_CTRL_OFS)) begin
			ctrlEnable_reg <= hwdata[`MDMD_CTRL_EN_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lastHeader_reg <= 6'h00;
			cmdCount_reg   <= 32'h0000_0000;
			frameDone_reg  <= 1'b0;
		end else begin
			if (commit) begin
				lastHeader_reg <= header;
			end
			// A command landing with a software clear is still counted.
			if (commit) begin
				cmdCount_reg <= countClr ? 32'h0000_0001 : cmdCount_reg + 32'h0000_0001;
			end else if (countClr) begin
				cmdCount_reg <= 32'h0000_0000;
			end
			if (commit) begin
				frameDone_reg <= 1'b0;
			end else if (state_reg == MDMD_DONE) begin
				frameDone_reg <= 1'b1; // R01
			end
		end
	end

	// Read data is registered at the address phase, so it stands in the data phase.
	logic [31:0] readMux;

	always_comb begin
		readMux = 32'h0000_0000;
		case ({haddr[7:2], 2'h0})
			`MDMD_CTRL_OFS: begin
				readMux[`MDMD_CTRL_EN_BIT] = ctrlEnable_reg;
			end
			`MDMD_STATUS_OFS: begin
				readMux[`MDMD_ST_MODE_MSB:`MDMD_ST_MODE_LSB] = modeNext;
				readMux[`MDMD_ST_COM_BIT]   = com_reg;
				readMux[`MDMD_ST_MODEF_BIT] = modeFlag_reg;
				readMux[`MDMD_ST_CLRF_BIT]  = clearFlag_reg;
				readMux[`MDMD_ST_BLINK_BIT] = blinkFlag_reg;
				readMux[`MDMD_ST_BCOL_BIT]  = blinkColor_reg;
				readMux[`MDMD_ST_BINV_BIT]  = blinkInv_reg;
				readMux[`MDMD_ST_DONE_BIT]  = frameDone_reg;
				readMux[`MDMD_ST_ACT_BIT]   = selS;
			end
			`MDMD_HEADER_OFS: begin
				readMux[5:0] = lastHeader_reg;
			end
			`MDMD_COUNT_OFS: begin
				readMux = cmdCount_reg;
			end
			default: begin
				readMux = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
		end else if (apValid && !hwrite) begin
			hrdata <= readMux;
		end
	end

endmodule

/* File: tb/mdmd_decoder_checker.sv */
// Assertions on the panel outputs of the mode decoder.
// Assumes it is bound to mdmd_decoder and sees only its ports.
`timescale 1ns/10ps
module mdmd_decoder_checker
	import mdmd_pkg::*;
(
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        rstn,
	// Serial select and panel control pins.
	input wire logic        serialSelect,
	input wire logic        displayOn,
	input wire logic        comSourceSelect,
	input wire logic        extComToggleIn,
	// Panel results.
	input wire mdmd_panel_s panelOut,
	input wire logic        commonElectrodeOut
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rstn);

	modeClear_a: assert property (
		!serialSelect [*6] |=> !panelOut.dataUpdateActive
		&& panelOut.displayMode != MDMD_ALL_CLEAR) else $error("Mode flags outlived select");
	dataMode_a: assert property (
		panelOut.dataUpdateActive |-> panelOut.displayMode == MDMD_DATA_UPDATE)
		else $error("Data update not shown");
	blinkOff_a: assert property (
		!displayOn [*6] |=> !(panelOut.displayMode inside {MDMD_BLINK_COLOR,
		MDMD_COLOR_INVERT})) else $error("Blink survived display off");
	clearShown_a: assert property (
		panelOut.allClearStrobe |-> ##[0:1] panelOut.displayMode inside
		{MDMD_ALL_CLEAR, MDMD_BLINK_COLOR, MDMD_COLOR_INVERT}) else $error("Clear not shown");
	strobeOnce_a: assert property (
		panelOut.allClearStrobe |=> !panelOut.allClearStrobe) else $error("Strobe too long");
	toggleFlip_a: assert property (
		comSourceSelect && $rose(extComToggleIn) |-> ##[2:6] $changed(commonElectrodeOut))
		else $error("Toggle did not flip");
	serialCom_a: assert property (
		!comSourceSelect && $changed(commonElectrodeOut) |-> $past(serialSelect, 3))
		else $error("Polarity moved outside a frame");
	extCom_a: assert property (
		comSourceSelect && $past(comSourceSelect, 8) && $changed(commonElectrodeOut)
		|-> $past(extComToggleIn, 2)) else $error("Polarity moved without toggle");
endmodule

bind mdmd_decoder mdmd_decoder_checker i_mdmd_decoder_checker (.mclk, .rstn,
	.serialSelect, .displayOn, .comSourceSelect, .extComToggleIn, .panelOut,
	.commonElectrodeOut);

/* File: tb/mdmd_host_model.sv */
// Host controller model sending mode frames on the serial port.
// Assumes the bench calls sendFrame and endFrame hierarchically.
`timescale 1ns/10ps
module mdmd_host_model (
	// Serial port.
	output logic serialSelect,
	output logic serialClk,
	output logic serialData
);
	initial begin
		serialSelect = 1'b0;
		serialClk    = 1'b0;
		serialData   = 1'b0;
	end

	// The clock stands still between frames, and released data shows the
	// inverse of its last bit so a stale read is caught.
	task automatic sendFrame(input logic [5:0] hdr, input int nBits, input logic fill);
		int i;
		serialSelect <= 1'b1;
		#250;
		for (i = 0; i < nBits; i++) begin
			serialData <= (i < 6) ? hdr[i] : fill;
			#62.5 serialClk <= 1'b1;
			#62.5 serialClk <= 1'b0;
		end
		serialData <= ~serialData;
		#250;
	endtask

	task automatic endFrame();
		serialSelect <= 1'b0;
		#250;
	endtask
endmodule

/* File: tb/mdmd_decoder_tb_top.sv */
// Self-checking bench of the mode decoder: bus, serial modes and polarity.
// Assumes the host model drives the serial port and the checker is bound.
`timescale 1ns/10ps
`include "mdmd_regs.svh"
module mdmd_decoder_tb_top
	import mdmd_pkg::*;
;
	logic        mclk, rstn, displayOn, comSourceSelect, extComToggleIn;
	logic        hsel, hwrite, serialSelect, serialClk, serialData;
	logic        hreadyout, hresp, commonElectrodeOut;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata, rdVal;
	mdmd_panel_s panelOut;
	int          numErrors, nChecks, nStrobe;
	logic [5:0]  hdrs [9] = '{6'h32, 6'h05, 6'h36, 6'h1A, 6'h08, 6'h3A, 6'h1C, 6'h00, 6'h01};
	mdmd_mode_e  mds [9] = '{MDMD_NO_UPDATE, MDMD_NO_UPDATE, MDMD_ALL_CLEAR, MDMD_BLINK_COLOR,
		MDMD_BLINK_COLOR, MDMD_COLOR_INVERT, MDMD_BLINK_COLOR, MDMD_NO_UPDATE, MDMD_DATA_UPDATE};

	mdmd_decoder i_mdmd_decoder (.mclk, .rstn, .serialSelect, .serialClk, .serialData,
		.displayOn, .comSourceSelect, .extComToggleIn, .panelOut, .commonElectrodeOut,
		.hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp);
	mdmd_host_model i_mdmd_host_model (.serialSelect, .serialClk, .serialData);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk)
		if (panelOut.allClearStrobe === 1'b1) nStrobe++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic results();
		if (numErrors == 0 && nChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic ahb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge mclk);
		htrans <= 2'h2;
		haddr  <= adr;
		hwrite <= wr;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rdVal = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic pulse();
		@(posedge mclk);
		extComToggleIn <= 1'b1;
		repeat (8) @(posedge mclk);
		extComToggleIn <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask

	task automatic testReset();
		chk({panelOut, commonElectrodeOut, hreadyout}, 32'h1);
		ahb(1'b0, `MDMD_CTRL_OFS, 32'h0);
		chk(rdVal, 32'h1);
		ahb(1'b1, 8'h10, 32'hFFFFFFFF);
		ahb(1'b0, 8'h10, 32'h0);
		chk(rdVal, 32'h0);
		ahb(1'b0, `MDMD_STATUS_OFS, 32'h0);
		chk(rdVal, 32'h0);
	endtask

	task automatic testModes();
		int i;
		for (i = 0; i < 9; i++) begin
			i_mdmd_host_model.sendFrame(hdrs[i], 16, i[0]);
			repeat (10) @(posedge mclk);
			chk(panelOut.displayMode, mds[i]);
			if (mds[i] != MDMD_COLOR_INVERT)
				chk(panelOut.blinkWhite, hdrs[i][4] & hdrs[i][3]);
			chk(commonElectrodeOut, hdrs[i][1]);
			i_mdmd_host_model.endFrame();
		end
		chk(panelOut.dataUpdateActive, 1'b0);
		ahb(1'b0, `MDMD_STATUS_OFS, 32'h0);
		chk({rdVal[10], rdVal[5:4]}, 32'h0);
		chk(rdVal[`MDMD_ST_DONE_BIT], 1'b1);
		chk(nStrobe, 32'h2);
		ahb(1'b0, `MDMD_COUNT_OFS, 32'h0);
		chk(rdVal, 32'h9);
		ahb(1'b0, `MDMD_HEADER_OFS, 32'h0);
		chk(rdVal, {26'h0, hdrs[8]});
		ahb(1'b1, `MDMD_COUNT_OFS, 32'h0);
	endtask

	task automatic testShort();
		i_mdmd_host_model.sendFrame(6'h18, 5, 1'b1);
		i_mdmd_host_model.endFrame();
		chk(panelOut.displayMode, MDMD_NO_UPDATE);
		ahb(1'b0, `MDMD_COUNT_OFS, 32'h0);
		chk(rdVal, 32'h0);
	endtask

	task automatic testDisplayOff();
		i_mdmd_host_model.sendFrame(6'h08, 16, 1'b0);
		i_mdmd_host_model.endFrame();
		chk(panelOut.displayMode, MDMD_BLINK_COLOR);
		@(posedge mclk);
		displayOn <= 1'b0;
		repeat (10) @(posedge mclk);
		chk(panelOut.displayMode, MDMD_NO_UPDATE);
		displayOn <= 1'b1;
	endtask

	task automatic testToggle();
		logic c0;
		@(posedge mclk);
		comSourceSelect <= 1'b1;
		repeat (10) @(posedge mclk);
		c0 = commonElectrodeOut;
		pulse();
		chk(commonElectrodeOut, !c0);
		i_mdmd_host_model.sendFrame({4'h0, c0, 1'b0}, 16, 1'b0);
		chk(commonElectrodeOut, !c0);
		i_mdmd_host_model.endFrame();
		pulse();
		chk(commonElectrodeOut, c0);
		comSourceSelect <= 1'b0;
	endtask

	// A frame that starts while decoding is switched off must change nothing.
	task automatic testDisable();
		ahb(1'b1, `MDMD_CTRL_OFS, 32'h0);
		i_mdmd_host_model.sendFrame(6'h08, 16, 1'b1);
		i_mdmd_host_model.endFrame();
		chk(panelOut.displayMode, MDMD_NO_UPDATE);
		ahb(1'b1, `MDMD_CTRL_OFS, 32'h1);
		i_mdmd_host_model.sendFrame(6'h08, 16, 1'b1);
		i_mdmd_host_model.endFrame();
		chk(panelOut.displayMode, MDMD_BLINK_COLOR);
	endtask

	// The whole run needs about 39 us, so this limit only trips on a hang.
	initial begin
		#400000;
		numErrors++;
		results();
	end

	initial begin
		rstn            = 1'b0;
		hsel            = 1'b1;
		htrans          = 2'h0;
		haddr           = 8'h0;
		hwrite          = 1'b0;
		hwdata          = 32'h0;
		displayOn       = 1'b1;
		comSourceSelect = 1'b0;
		extComToggleIn  = 1'b0;
		numErrors       = 0;
		nChecks         = 0;
		nStrobe         = 0;
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		testReset();
		testModes();
		testShort();
		testDisplayOff();
		testToggle();
		testDisable();
		results();
	end
endmodule
